// *** aal_params.svh ***
// Purpose: Offsets, field positions and reset values of the add and logic datapath
// Assumes: Byte addresses on a 32-bit classic Wishbone slave, one register per word
// Notes:   Included by its bare name from the datapath module
`ifndef AAL_PARAMS_SVH
`define AAL_PARAMS_SVH

// Register byte offsets
`define AAL_OFS_CMD   8'h00
`define AAL_OFS_OPND  8'h04
`define AAL_OFS_ACCA  8'h08
`define AAL_OFS_ACCB  8'h0C
`define AAL_OFS_ACCD  8'h10
`define AAL_OFS_CCR   8'h14
`define AAL_OFS_STAT  8'h18

// Condition code bit positions
`define AAL_CCR_S     7
`define AAL_CCR_X     6
`define AAL_CCR_H     5
`define AAL_CCR_I     4
`define AAL_CCR_N     3
`define AAL_CCR_Z     2
`define AAL_CCR_V     1
`define AAL_CCR_C     0

// Operand bit that feeds the half-carry
`define AAL_HALF_BIT  3

// Mask whose only zero is the interrupt mask position
`define AAL_IMASK_CLR 8'hEF

// Command and status fields
`define AAL_CMD_OP_MSB   2
`define AAL_STAT_OPEN    0
`define AAL_STAT_BAD     1
`define AAL_STAT_OP_LSB  4
`define AAL_STAT_OP_MSB  6

// Reset values
`define AAL_RST_CCR   8'h10
`define AAL_RST_ACC   8'h00
`define AAL_RST_OPND  16'h0000

`endif

// *** aal_pkg.sv ***
// Purpose: Types shared by the add and logic datapath
// Assumes: Constants live in aal_params.svh
// Notes:   All module state is one packed struct
`default_nettype none
package aal_pkg;

   // Operations started by a write to the command register
   typedef enum logic [2:0] {
      OP_ADD_SECOND  = 3'h0,
      OP_DOUBLE_ADD  = 3'h1,
      OP_AND_FIRST   = 3'h2,
      OP_AND_SECOND  = 3'h3,
      OP_MASK_FLAGS  = 3'h4,
      OP_CLEAR_IMASK = 3'h5,
      OP_SPARE       = 3'h6,
      OP_IDLE        = 3'h7
   } aal_op_e;

   // Whole state of the datapath
   typedef struct packed {
      logic [7:0]  accA;
      logic [7:0]  accB;
      logic [7:0]  condition_code_register;
      logic [15:0] operand;
      aal_op_e     lastOp;
      logic        badOp;
      logic        exec;
      logic        holdOff;
      logic        intOpen;
      logic        ack;
      logic [31:0] rdata;
   } aal_state_s;

endpackage
`default_nettype wire

// *** aal_alu.sv ***
// Purpose: Add and logic datapath with condition flags behind a Wishbone slave
// Assumes: Sequencer writes the memory operand, then the command; one op per write
// Notes:   Operation and flags commit on the edge that completes the command write
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`include "aal_params.svh"
`timescale 1ns/1ns
`default_nettype none

module aal_alu (
   input  wire logic        clock,    // Core clock, 125 MHz
   input  wire logic        rst_n,    // Asynchronous reset, active low
   input  wire logic        cyc_i,    // Wishbone cycle
   input  wire logic        stb_i,    // Wishbone strobe
   input  wire logic        we_i,     // Wishbone write enable
   input  wire logic [7:0]  adr_i,    // Wishbone byte address
   input  wire logic [3:0]  sel_i,    // Wishbone byte lanes
   input  wire logic [31:0] dat_i,    // Wishbone write data
   output logic      [31:0] dat_o,    // Wishbone read data
   output logic             ack_o,    // Wishbone acknowledge
   output logic      [7:0]  accA,     // First accumulator
   output logic      [7:0]  accB,     // Second accumulator
   output logic      [7:0]  condition_code_register,      // Condition code register
   output logic             intOpen   // Interrupt requests may be accepted
);

   aal_pkg::aal_state_s s_q;
   aal_pkg::aal_state_s s_d;
   aal_pkg::aal_op_e    opIn;
   logic [7:0]          sum8;
   logic [15:0]         sum16;
   logic [7:0]          and8;
   logic [31:0]         rdNext;
   logic                wrFire;
   logic                rdTake;

   // Carry term a.m + m.~r + ~r.a
   function automatic logic carryTerm(input logic a, input logic m, input logic r);
      return (a & m) | (m & ~r) | (~r & a);
   endfunction

   // Two's complement overflow term a.m.~r + ~a.~m.r
   function automatic logic ovfTerm(input logic a, input logic m, input logic r);
      return (a & m & ~r) | (~a & ~m & r);
   endfunction

   // Flag register with negative and zero taken from an 8-bit result
   function automatic logic [7:0] withNz8(input logic [7:0] f, input logic [7:0] res);
      logic [7:0] o;
      o = f;
      o[`AAL_CCR_N] = res[7];
      o[`AAL_CCR_Z] = ~|res;
      return o;
   endfunction

   // Merge the two low byte lanes of a write into a 16-bit value
   function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                              input logic [15:0] nw,
                                              input logic [1:0]  sel);
      logic [15:0] o;
      o = old;
      if (sel[0]) begin
         o[7:0] = nw[7:0];
      end
      if (sel[1]) begin
         o[15:8] = nw[15:8];
      end
      return o;
   endfunction

   // Bus events: write commits and read data is latched
   assign wrFire = cyc_i & stb_i & we_i & s_q.ack;
   assign rdTake = cyc_i & stb_i & ~we_i & ~s_q.ack;

   // Read multiplexer, unmapped addresses read zero
   always_comb begin
      rdNext = 32'h0000_0000;
      case (adr_i)
         `AAL_OFS_CMD: begin
            rdNext[`AAL_CMD_OP_MSB:0] = s_q.lastOp;
         end
         `AAL_OFS_OPND: begin
            rdNext[15:0] = s_q.operand;
         end
         `AAL_OFS_ACCA: begin
            rdNext[7:0] = s_q.accA;
         end
         `AAL_OFS_ACCB: begin
            rdNext[7:0] = s_q.accB;
         end
         `AAL_OFS_ACCD: begin
            rdNext[15:0] = {s_q.accA, s_q.accB};
         end
         `AAL_OFS_CCR: begin
            rdNext[7:0] = s_q.condition_code_register;
         end
         `AAL_OFS_STAT: begin
            rdNext[`AAL_STAT_OPEN] = s_q.intOpen;
            rdNext[`AAL_STAT_BAD] = s_q.badOp;
            rdNext[`AAL_STAT_OP_MSB:`AAL_STAT_OP_LSB] = s_q.lastOp;
         end
         default: begin
            rdNext = 32'h0000_0000;
         end
      endcase
   end

   // Next state: bus answer, register writes and operation execution
   always_comb begin
      s_d = s_q;
      opIn = aal_pkg::aal_op_e'(dat_i[`AAL_CMD_OP_MSB:0]);
      sum8 = 8'(s_q.accB + s_q.operand[7:0]);
      sum16 = 16'({s_q.accA, s_q.accB} + s_q.operand);
      and8 = 8'h00;
      s_d.ack = cyc_i & stb_i & ~s_q.ack;
      s_d.exec = 1'b0;
      if (rdTake) begin
         s_d.rdata = rdNext;
      end
      if (wrFire) begin
         case (adr_i)
            `AAL_OFS_CMD: begin
               if (sel_i[0]) begin
                  s_d.exec = 1'b1;
                  s_d.lastOp = opIn;
                  s_d.badOp = 1'b0;
                  // Flags not listed for an operation keep their values
                  case (opIn)
                     aal_pkg::OP_ADD_SECOND: begin
                        s_d.accB = sum8;
                        s_d.condition_code_register[`AAL_CCR_H] = carryTerm(s_q.accB[`AAL_HALF_BIT],
                           s_q.operand[`AAL_HALF_BIT], sum8[`AAL_HALF_BIT]);
                        s_d.condition_code_register = withNz8(s_d.condition_code_register, sum8);
                        s_d.condition_code_register[`AAL_CCR_V] = ovfTerm(s_q.accB[7],
                           s_q.operand[7], sum8[7]);
                        s_d.condition_code_register[`AAL_CCR_C] = carryTerm(s_q.accB[7],
                           s_q.operand[7], sum8[7]);
                     end
                     aal_pkg::OP_DOUBLE_ADD: begin
                        {s_d.accA, s_d.accB} = sum16;
                        s_d.condition_code_register[`AAL_CCR_N] = sum16[15];
                        s_d.condition_code_register[`AAL_CCR_Z] = ~|sum16;
                        s_d.condition_code_register[`AAL_CCR_V] = ovfTerm(s_q.accA[7],
                           s_q.operand[15], sum16[15]);
                        s_d.condition_code_register[`AAL_CCR_C] = carryTerm(s_q.accA[7],
                           s_q.operand[15], sum16[15]);
                     end
                     aal_pkg::OP_AND_FIRST: begin
                        and8 = s_q.accA & s_q.operand[7:0];
                        s_d.accA = and8;
                        s_d.condition_code_register = withNz8(s_d.condition_code_register, and8);
                        s_d.condition_code_register[`AAL_CCR_V] = 1'b0;
                     end
                     aal_pkg::OP_AND_SECOND: begin
                        and8 = s_q.accB & s_q.operand[7:0];
                        s_d.accB = and8;
                        s_d.condition_code_register = withNz8(s_d.condition_code_register, and8);
                        s_d.condition_code_register[`AAL_CCR_V] = 1'b0;
                     end
                     aal_pkg::OP_MASK_FLAGS: begin
                        s_d.condition_code_register = s_q.condition_code_register & s_q.operand[7:0];
                     end
                     aal_pkg::OP_CLEAR_IMASK: begin
                        s_d.condition_code_register = s_q.condition_code_register & `AAL_IMASK_CLR;
                     end
                     default: begin
                        s_d.badOp = 1'b1;
                        s_d.exec = 1'b0;
                        s_d.lastOp = s_q.lastOp;
                     end
                  endcase
               end
            end
            `AAL_OFS_OPND: begin
               s_d.operand = mergeLanes(s_q.operand, dat_i[15:0], sel_i[1:0]);
            end
            `AAL_OFS_ACCA: begin
               if (sel_i[0]) begin
                  s_d.accA = dat_i[7:0];
               end
            end
            `AAL_OFS_ACCB: begin
               if (sel_i[0]) begin
                  s_d.accB = dat_i[7:0];
               end
            end
            `AAL_OFS_ACCD: begin
               {s_d.accA, s_d.accB} = mergeLanes({s_q.accA, s_q.accB},
                  dat_i[15:0], sel_i[1:0]);
            end
            `AAL_OFS_CCR: begin
               if (sel_i[0]) begin
                  s_d.condition_code_register = dat_i[7:0];
               end
            end
            default: begin
               s_d.exec = 1'b0;
            end
         endcase
      end
      // A falling interrupt mask holds requests off for one more cycle
      s_d.holdOff = s_q.condition_code_register[`AAL_CCR_I] & ~s_d.condition_code_register[`AAL_CCR_I];
      s_d.intOpen = ~s_d.condition_code_register[`AAL_CCR_I] & ~s_d.holdOff;
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.accA <= `AAL_RST_ACC;
         s_q.accB <= `AAL_RST_ACC;
         s_q.condition_code_register <= `AAL_RST_CCR;
         s_q.operand <= `AAL_RST_OPND;
         s_q.lastOp <= aal_pkg::OP_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign dat_o = s_q.rdata;
   assign ack_o = s_q.ack;
   assign accA = s_q.accA;
   assign accB = s_q.accB;
   assign condition_code_register = s_q.condition_code_register;
   assign intOpen = s_q.intOpen;

   // Checks on committed results and flags
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // Completed operation of a given kind
   sequence doneOp(aal_pkg::aal_op_e op);
      s_q.exec && s_q.lastOp == op;
   endsequence

   // Interrupt mask just cleared
   sequence maskFell;
      $fell(s_q.condition_code_register[`AAL_CCR_I]);
   endsequence

   AST_ADD_SECOND: assert property (s_q.exec ##0 doneOp(aal_pkg::OP_ADD_SECOND) |->
      s_q.accB == 8'($past(s_q.accB) + $past(s_q.operand[7:0])) && s_q.accA == $past(s_q.accA))
      else $error("second accumulator add result wrong");

   AST_HALF_CARRY: assert property (doneOp(aal_pkg::OP_ADD_SECOND) |->
      s_q.condition_code_register[`AAL_CCR_H] == (5'($past(s_q.accB[3:0]))
      + 5'($past(s_q.operand[3:0])) > 5'h0F))
      else $error("half-carry flag wrong after add");

   AST_NEG_ZERO: assert property (doneOp(aal_pkg::OP_ADD_SECOND) or
      doneOp(aal_pkg::OP_AND_SECOND) |->
      s_q.condition_code_register[`AAL_CCR_N] == s_q.accB[7] && s_q.condition_code_register[`AAL_CCR_Z] == (s_q.accB == 8'h00))
      else $error("negative or zero flag wrong");

   AST_OVERFLOW: assert property (doneOp(aal_pkg::OP_ADD_SECOND) |->
      s_q.condition_code_register[`AAL_CCR_V] == ($past(s_q.accB[7]) == $past(s_q.operand[7])
      && s_q.accB[7] != $past(s_q.accB[7])))
      else $error("overflow flag wrong after add");

   AST_CARRY: assert property (doneOp(aal_pkg::OP_ADD_SECOND) |->
      s_q.condition_code_register[`AAL_CCR_C] == (9'($past(s_q.accB)) + 9'($past(s_q.operand[7:0])) > 9'h0FF))
      else $error("carry flag wrong after add");

   AST_DOUBLE_ADD: assert property (doneOp(aal_pkg::OP_DOUBLE_ADD) |->
      {s_q.accA, s_q.accB} == 16'({$past(s_q.accA), $past(s_q.accB)} + $past(s_q.operand)))
      else $error("double accumulator sum wrong");

   AST_DOUBLE_WRITE: assert property (wrFire && adr_i == `AAL_OFS_ACCD && sel_i[1:0] == 2'h3
      |=> {s_q.accA, s_q.accB} == $past(dat_i[15:0]))
      else $error("double accumulator write did not split");

   AST_DOUBLE_FLAGS: assert property (doneOp(aal_pkg::OP_DOUBLE_ADD) |->
      $stable(s_q.condition_code_register[`AAL_CCR_H]) && s_q.condition_code_register[`AAL_CCR_Z] == ({s_q.accA, s_q.accB} == 16'h0000)
      && s_q.condition_code_register[`AAL_CCR_C] == (17'({$past(s_q.accA), $past(s_q.accB)})
      + 17'($past(s_q.operand)) > 17'h0FFFF))
      else $error("double add flags wrong");

   AST_AND_RESULT: assert property (doneOp(aal_pkg::OP_AND_FIRST) |->
      s_q.accA == ($past(s_q.accA) & $past(s_q.operand[7:0])) && $stable(s_q.accB))
      else $error("AND result wrong");

   AST_AND_FLAGS: assert property (doneOp(aal_pkg::OP_AND_FIRST) or
      doneOp(aal_pkg::OP_AND_SECOND) |->
      !s_q.condition_code_register[`AAL_CCR_V] && $stable(s_q.condition_code_register[`AAL_CCR_C]) && $stable(s_q.condition_code_register[`AAL_CCR_H])
      && $stable(s_q.condition_code_register[7:4]))
      else $error("AND disturbed flags it must keep");

   AST_MASK_FLAGS: assert property (doneOp(aal_pkg::OP_MASK_FLAGS) |->
      s_q.condition_code_register == ($past(s_q.condition_code_register) & $past(s_q.operand[7:0])))
      else $error("flag mask result wrong");

   AST_INT_DELAY: assert property (maskFell |->
      !s_q.intOpen ##1 (s_q.intOpen || s_q.condition_code_register[`AAL_CCR_I]))
      else $error("interrupt acceptance not delayed one cycle");

   AST_CLEAR_IMASK: assert property (doneOp(aal_pkg::OP_CLEAR_IMASK) |->
      s_q.condition_code_register == ($past(s_q.condition_code_register) & `AAL_IMASK_CLR))
      else $error("clear interrupt mask wrong");

   AST_KEEP_STATE: assert property (!wrFire |=>
      $stable(s_q.condition_code_register) && $stable(s_q.accA) && $stable(s_q.accB))
      else $error("state changed without a committed write");

   AST_AND_FIRST_NZ: assert property (doneOp(aal_pkg::OP_AND_FIRST) |->
      s_q.condition_code_register[`AAL_CCR_N] == s_q.accA[7] && s_q.condition_code_register[`AAL_CCR_Z] == (s_q.accA == 8'h00))
      else $error("negative or zero flag wrong after AND into first");

   AST_DOUBLE_SIGN: assert property (doneOp(aal_pkg::OP_DOUBLE_ADD) |->
      s_q.condition_code_register[`AAL_CCR_N] == s_q.accA[7]
      && s_q.condition_code_register[`AAL_CCR_V] == ($past(s_q.accA[7]) == $past(s_q.operand[15])
      && s_q.accA[7] != $past(s_q.accA[7])))
      else $error("double add negative or overflow flag wrong");

   AST_AND_SECOND: assert property (doneOp(aal_pkg::OP_AND_SECOND) |->
      s_q.accB == ($past(s_q.accB) & $past(s_q.operand[7:0])) && $stable(s_q.accA))
      else $error("AND into second result wrong");

   // Control bits ride through an add untouched
   AST_ADD_KEEPS: assert property (doneOp(aal_pkg::OP_ADD_SECOND) |->
      $stable(s_q.condition_code_register[7:6]) && $stable(s_q.condition_code_register[`AAL_CCR_I]))
      else $error("add disturbed control bits");

   AST_DOUBLE_KEEPS: assert property (doneOp(aal_pkg::OP_DOUBLE_ADD) |->
      $stable(s_q.condition_code_register[7:4]))
      else $error("double add disturbed bits it must keep");

   // A refused command code changes nothing but the bad flag
   AST_BAD_CMD: assert property (wrFire && adr_i == `AAL_OFS_CMD && sel_i[0]
      && dat_i[2:1] == 2'h3 |=> s_q.badOp && !s_q.exec && $stable(s_q.lastOp)
      && $stable(s_q.condition_code_register) && $stable(s_q.accA) && $stable(s_q.accB))
      else $error("refused command changed state");

endmodule
`default_nettype wire

// *** aal_seq_model.sv ***
// Purpose: Sequencer model that hands operands and commands to the datapath over Wishbone
// Assumes: Classic single cycles, one outstanding request, bench watchdog ends a hung wait
// Notes:   Released data lines show the inverse of the last value, never a stale copy
`timescale 1ns/1ns
`default_nettype none

module aal_seq_model (
   input  wire logic        clock,  // Core clock
   input  wire logic        rst_n,  // Reset, active low
   output logic             cyc,    // Wishbone cycle
   output logic             stb,    // Wishbone strobe
   output logic             we,     // Wishbone write enable
   output logic      [7:0]  adr,    // Wishbone byte address
   output logic      [3:0]  sel,    // Wishbone byte lanes
   output logic      [31:0] dat,    // Wishbone write data
   input  wire logic [31:0] rdat,   // Wishbone read data
   input  wire logic        ack     // Wishbone acknowledge
);
   // Idle bus at time zero
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we  = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h00000000;
   end

   // One classic cycle: hold everything until ack is sampled high, then release
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      do begin
         @(posedge clock);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      dat <= ~d;
   endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for the add and logic datapath
// Assumes: Sequencer model drives the bus; expectations come from a reference of the flags
// Notes:   Each operation is checked on accumulators and flags right after its commit edge
`include "aal_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   logic        clock;
   logic        rst_n;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic [7:0]  accA;
   logic [7:0]  accB;
   logic [7:0]  condition_code_register;
   logic        intOpen;
   logic [7:0]  eA;
   logic [7:0]  eB;
   logic [7:0]  eC;
   logic [31:0] q;
   int          fails;
   int          checks_done;
   logic [15:0] addT [5] = '{16'h0808, 16'h7F01, 16'hFF01, 16'h0000, 16'h8080};
   logic [31:0] dblT [4] = '{32'h7FFF0001, 32'hFFFF0001, 32'h12340F0F, 32'h80008000};
   logic [7:0]  andT [3] = '{8'h80, 8'h0F, 8'h00};

   aal_seq_model i_aal_seq_model (.clock(clock), .rst_n(rst_n), .cyc(cyc), .stb(stb),
      .we(we), .adr(adr), .sel(sel), .dat(wdat), .rdat(rdat), .ack(ack));

   aal_alu i_aal_alu (.clock(clock), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .accA(accA),
      .accB(accB), .condition_code_register(condition_code_register), .intOpen(intOpen));

   // Clock of 8 ns
   initial clock = 1'b0;
   always #4 clock = ~clock;

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic results;
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      logic [31:0] r;
      i_aal_seq_model.xfer(1'b1, a, s, d, r);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      i_aal_seq_model.xfer(1'b0, a, 4'hF, 32'h00000000, r);
   endtask

   // Reference of results and flags
   task automatic refOp(input logic [2:0] op, input logic [15:0] m);
      logic [8:0]  s9;
      logic [4:0]  h5;
      logic [16:0] s17;
      case (op)
         3'h0: begin
            s9 = {1'b0, eB} + {1'b0, m[7:0]};
            h5 = {1'b0, eB[3:0]} + {1'b0, m[3:0]};
            eC[`AAL_CCR_H] = h5[4];
            eC[`AAL_CCR_V] = (eB[7] == m[7]) && (s9[7] != eB[7]);
            eC[`AAL_CCR_C] = s9[8];
            eB = s9[7:0];
            eC[`AAL_CCR_N] = eB[7];
            eC[`AAL_CCR_Z] = (eB == 8'h00);
         end
         3'h1: begin
            s17 = {1'b0, eA, eB} + {1'b0, m};
            eC[`AAL_CCR_V] = (eA[7] == m[15]) && (s17[15] != eA[7]);
            eC[`AAL_CCR_C] = s17[16];
            {eA, eB} = s17[15:0];
            eC[`AAL_CCR_N] = s17[15];
            eC[`AAL_CCR_Z] = (s17[15:0] == 16'h0000);
         end
         3'h2, 3'h3: begin
            if (op == 3'h2) eA = eA & m[7:0];
            else eB = eB & m[7:0];
            eC[`AAL_CCR_N] = (op == 3'h2) ? eA[7] : eB[7];
            eC[`AAL_CCR_Z] = ((op == 3'h2) ? eA : eB) == 8'h00;
            eC[`AAL_CCR_V] = 1'b0;
         end
         3'h4: eC = eC & m[7:0];
         3'h5: eC = eC & `AAL_IMASK_CLR;
         default: ;
      endcase
   endtask

   // Operand, command, then compare at the commit
   task automatic doOp(input logic [2:0] op, input logic [15:0] m);
      wr(`AAL_OFS_OPND, 4'h3, {16'h0000, m});
      wr(`AAL_OFS_CMD, 4'h1, {29'h0, op});
      #1;
      refOp(op, m);
      chk({8'h00, accA, accB, condition_code_register}, {8'h00, eA, eB, eC});
   endtask

   // Watchdog
   initial begin
      #100000;
      fails++;
      results();
   end

   // Main sequence
   initial begin
      fails = 0;
      checks_done = 0;
      rst_n = 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      chk({accA, accB, condition_code_register, 7'h00, intOpen}, {16'h0000, `AAL_RST_CCR, 8'h00});
      rd(`AAL_OFS_STAT, q);
      chk(q, 32'h00000070);
      eA = 8'h7F;
      eB = 8'hFF;
      eC = 8'hD0;
      wr(`AAL_OFS_ACCD, 4'h3, 32'h00007FFF);
      wr(`AAL_OFS_CCR, 4'h1, 32'h000000D0);
      rd(`AAL_OFS_ACCA, q);
      chk(q, 32'h0000007F);
      rd(`AAL_OFS_ACCB, q);
      chk(q, 32'h000000FF);
      rd(`AAL_OFS_ACCD, q);
      chk(q, 32'h00007FFF);
      rd(`AAL_OFS_CCR, q);
      chk(q, 32'h000000D0);
      // Upper lane of the operand written alone; byte M sits in the lower lane
      wr(`AAL_OFS_OPND, 4'h2, 32'h0000AB00);
      rd(`AAL_OFS_OPND, q);
      chk(q, 32'h0000AB00);
      // Adds into the second accumulator
      foreach (addT[i]) begin
         wr(`AAL_OFS_ACCB, 4'h1, {24'h0, addT[i][15:8]});
         eB = addT[i][15:8];
         doOp(3'h0, {8'h00, addT[i][7:0]});
      end
      // Double adds, half-carry left alone
      foreach (dblT[i]) begin
         wr(`AAL_OFS_ACCD, 4'h3, {16'h0, dblT[i][31:16]});
         {eA, eB} = dblT[i][31:16];
         doOp(3'h1, dblT[i][15:0]);
      end
      // AND into each accumulator, carry kept, overflow cleared
      foreach (andT[i]) begin
         wr(`AAL_OFS_ACCD, 4'h3, 32'h0000F0F8);
         {eA, eB} = 16'hF0F8;
         doOp(3'h2, {8'h00, andT[i]});
         doOp(3'h3, {8'h00, andT[i]});
      end
      // Mask keeping the interrupt bit, then clearing it
      wr(`AAL_OFS_CCR, 4'h1, 32'h000000FF);
      eC = 8'hFF;
      doOp(3'h4, 16'h00B5);
      chk({31'h0, intOpen}, 32'h00000000);
      doOp(3'h5, 16'h0000);
      chk({31'h0, intOpen}, 32'h00000000);
      @(posedge clock);
      #1;
      chk({31'h0, intOpen}, 32'h00000001);
      rd(`AAL_OFS_STAT, q);
      chk(q, 32'h00000051);
      // Refused commands and places leave the state alone
      wr(`AAL_OFS_CMD, 4'h1, 32'h00000006);
      wr(`AAL_OFS_CMD, 4'h2, 32'h00000002);
      wr(8'h1C, 4'hF, 32'hFFFFFFFF);
      #1;
      chk({8'h00, accA, accB, condition_code_register}, {8'h00, eA, eB, eC});
      rd(`AAL_OFS_STAT, q);
      chk(q, 32'h00000053);
      rd(`AAL_OFS_CMD, q);
      chk(q, 32'h00000005);
      rd(8'h1C, q);
      chk(q, 32'h00000000);
      results();
   end
endmodule
`default_nettype wire
